// ### verilog/odcu_pkg.sv
package odcu_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ_REV     = 8'h00;
  localparam logic [7:0] CMD_RESERVED     = 8'h01;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h02;
  localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
  localparam logic [7:0] CMD_WRITE_CTRL   = 8'h04;
  localparam logic [7:0] CMD_READ_CTRL    = 8'h05;
  localparam logic [7:0] CMD_READ_DMEM    = 8'h0D;
  localparam logic [7:0] CMD_READ_CRC     = 8'h0E;
  localparam logic [7:0] CMD_STEP         = 8'h10;
  localparam logic [7:0] CMD_STUFF        = 8'h11;
  localparam logic [7:0] CMD_EXEC         = 8'h12;

  // Opcode treated as a breakpoint (erased-to-programmed flash byte)
  localparam logic [7:0] BREAKPOINT_OPCODE = 8'h00;

  // Control register fields and reset value
  localparam int         CTRL_DEBUG_BIT = 7;
  localparam int         CTRL_BRKEN_BIT = 6;
  localparam logic [7:0] CTRL_RESET     = 8'h00;

  // Status register fields
  localparam int STAT_DEBUG_BIT = 7;
  localparam int STAT_RPROT_BIT = 6;
  localparam int STAT_WPROT_BIT = 5;

  // Protection levels
  localparam logic [1:0] PROT_NONE  = 2'h0;
  localparam logic [1:0] PROT_READ  = 2'h1;
  localparam logic [1:0] PROT_WRITE = 2'h2;

  // Counter and filler values
  localparam logic [15:0] RUNTIME_MAX  = 16'hFFFF;
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_BLOCKED  = 16'hFFFF;
  localparam logic [15:0] WORD_BLOCKED = 16'hFFFF;
  localparam logic [7:0]  DATA_BLOCKED = 8'hFF;

  // Debugger revision, value arbitrary
  localparam logic [15:0] DEBUG_REVISION = 16'h0001;

  // Default program memory size in bytes
  localparam int PMEM_BYTES_DEFAULT = 1024;

  typedef enum logic [3:0] {
    ST_CMD, ST_ARG, ST_RUN, ST_SEND, ST_DREAD, ST_DWAIT, ST_CRC, ST_ELEN, ST_EXEC
  } odcu_state_type;

  typedef enum logic [1:0] {H_IDLE, H_TX, H_RX} odcu_hstate_type;
endpackage

// ### verilog/odcu_link_if.sv
`timescale 1ns/1ps
// Byte stream of the single-wire debug link, one channel each way
interface odcu_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;

  modport device (input h2d_data, input h2d_valid, output h2d_ready,
                  output d2h_data, output d2h_valid, input d2h_ready);
  modport host   (output h2d_data, output h2d_valid, input h2d_ready,
                  input d2h_data, input d2h_valid, output d2h_ready);
endinterface

// ### verilog/odcu_device.sv
`timescale 1ns/1ps
// Overview of operation
// - Option bits select one of three protection levels
// - Opcode 00H is the breakpoint instruction
// - 16-bit runtime counter, counts outside debug, saturates
// - Outside debug only a command subset works
// - Decode revision, status, runtime, control read codes
// - Control write anytime; read protect keeps debug bit
// - Data read: code, address, size; zero means 65536
// - Data read outside debug returns FFH bytes
// - Command 0EH returns CRC-CCITT of program memory
// - CRC outside debug returns FFFFH immediately
// - CRC reply delayed about one cycle per byte
// - Step one instruction, only in debug and not read protected
// - Stuff host opcode, rest fetched from memory
// - Execute host instruction, length known from opcode
module odcu_device #(
  parameter int PMEM_BYTES = odcu_pkg::PMEM_BYTES_DEFAULT
) (
  odcu_link_if.device link,
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       flash_read_protect_option,
  input  wire logic       flash_write_protect_option,
  output logic [1:0]      protect_level,
  output logic            debug_mode_control_bit,
  output logic            dmem_rd,
  output logic [15:0]     dmem_addr,
  input  wire logic [7:0] dmem_rdata,
  output logic            pmem_rd,
  output logic [15:0]     pmem_addr,
  input  wire logic [7:0] pmem_rdata,
  input  wire logic       fetch_valid,
  input  wire logic [7:0] fetch_opcode,
  output logic            breakpoint_hit,
  output logic            cpu_step,
  output logic            cpu_stuff,
  output logic            cpu_exec_valid,
  output logic            cpu_exec_first,
  output logic [7:0]      cpu_byte,
  input  wire logic [2:0] cpu_instr_len
);
  import odcu_pkg::*;

  localparam logic [16:0] PMEM_END = 17'(PMEM_BYTES);

  odcu_state_type state_reg, state_next;
  logic [7:0]  cmd_reg, cmd_next;
  logic [31:0] arg_reg, arg_next;
  logic [2:0]  argcnt_reg, argcnt_next;
  logic [15:0] tx_reg, tx_next;
  logic [1:0]  txcnt_reg, txcnt_next;
  logic [7:0]  ctrl_reg, ctrl_next;
  logic [15:0] runtime_reg, runtime_next;
  logic [15:0] addr_reg, addr_next;
  logic [16:0] left_reg, left_next;
  logic [15:0] crc_reg, crc_next;
  logic [16:0] caddr_reg, caddr_next;
  logic        h2d_ready_reg, h2d_ready_next;
  logic [7:0]  d2h_data_reg, d2h_data_next;
  logic        d2h_valid_reg, d2h_valid_next;
  logic        dmem_rd_reg, dmem_rd_next, dmem_rd_d_reg;
  logic [15:0] dmem_addr_reg, dmem_addr_next;
  logic        pmem_rd_reg, pmem_rd_next, pmem_rd_d_reg;
  logic [15:0] pmem_addr_reg, pmem_addr_next;
  logic        bkpt_reg, bkpt_next;
  logic        step_reg, step_next;
  logic        stuff_reg, stuff_next;
  logic        exv_reg, exv_next;
  logic        exf_reg, exf_next;
  logic [7:0]  cbyte_reg, cbyte_next;
  logic [1:0]  prot_reg, prot_next;
  logic        rx, txdone, dmode, rprot, exec_ok;
  logic [7:0]  status, wval;

  // One CRC-CCITT byte step, MSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ((x << 1) ^ CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  // Next-state logic of the command handler
  always_comb begin
    state_next     = state_reg;
    cmd_next       = cmd_reg;
    arg_next       = arg_reg;
    argcnt_next    = argcnt_reg;
    tx_next        = tx_reg;
    txcnt_next     = txcnt_reg;
    ctrl_next      = ctrl_reg;
    runtime_next   = runtime_reg;
    addr_next      = addr_reg;
    left_next      = left_reg;
    crc_next       = crc_reg;
    caddr_next     = caddr_reg;
    d2h_data_next  = d2h_data_reg;
    d2h_valid_next = d2h_valid_reg;
    dmem_rd_next   = 1'b0;
    dmem_addr_next = dmem_addr_reg;
    pmem_rd_next   = 1'b0;
    pmem_addr_next = pmem_addr_reg;
    bkpt_next      = 1'b0;
    step_next      = 1'b0;
    stuff_next     = 1'b0;
    exv_next       = 1'b0;
    exf_next       = exf_reg;
    cbyte_next     = cbyte_reg;
    rx       = link.h2d_valid && h2d_ready_reg;
    txdone   = d2h_valid_reg && link.d2h_ready;
    dmode    = ctrl_reg[CTRL_DEBUG_BIT];
    rprot    = flash_read_protect_option;
    exec_ok  = dmode && !rprot;
    status   = 8'h00;
    status[STAT_DEBUG_BIT] = dmode;
    status[STAT_RPROT_BIT] = rprot;
    status[STAT_WPROT_BIT] = flash_write_protect_option;
    wval     = arg_reg[7:0];
    if (flash_write_protect_option) begin
      prot_next = PROT_WRITE;
    end else if (rprot) begin
      prot_next = PROT_READ;
    end else begin
      prot_next = PROT_NONE;
    end
    // Breakpoint opcode stops the core when enabled, else acts as no-op
    if (!dmode && fetch_valid && fetch_opcode == BREAKPOINT_OPCODE
        && ctrl_reg[CTRL_BRKEN_BIT]) begin
      ctrl_next[CTRL_DEBUG_BIT] = 1'b1;
      bkpt_next = 1'b1;
    end
    // Reply byte pump, back to back when the host is ready
    if (txdone) begin
      d2h_valid_next = 1'b0;
    end
    case (state_reg)
      ST_CMD: begin
        if (rx) begin
          cmd_next = link.h2d_data;
          case (link.h2d_data)
            CMD_WRITE_CTRL, CMD_STUFF, CMD_EXEC: argcnt_next = 3'd1;
            CMD_READ_DMEM: argcnt_next = 3'd4;
            default: argcnt_next = 3'd0;
          endcase
          state_next = (argcnt_next != 3'd0) ? ST_ARG : ST_RUN;
        end
      end
      ST_ARG: begin
        if (rx) begin
          arg_next    = {arg_reg[23:0], link.h2d_data};
          argcnt_next = argcnt_reg - 3'd1;
          if (argcnt_reg == 3'd1) begin
            state_next = ST_RUN;
          end
        end
      end
      ST_RUN: begin
        state_next = ST_CMD;
        case (cmd_reg)
          CMD_READ_REV: begin
            tx_next = DEBUG_REVISION;
            txcnt_next = 2'd2;
            state_next = ST_SEND;
          end
          CMD_READ_STATUS: begin
            tx_next = {status, 8'h00};
            txcnt_next = 2'd1;
            state_next = ST_SEND;
          end
          CMD_READ_RUNTIME: begin
            tx_next = dmode ? runtime_reg : WORD_BLOCKED;
            txcnt_next = 2'd2;
            state_next = ST_SEND;
          end
          CMD_WRITE_CTRL: begin
            if (rprot && dmode) begin
              wval[CTRL_DEBUG_BIT] = 1'b1;
            end
            // A breakpoint in the same cycle still stops the core
            if (bkpt_next) begin
              wval[CTRL_DEBUG_BIT] = 1'b1;
            end
            ctrl_next = wval;
          end
          CMD_READ_CTRL: begin
            tx_next = {ctrl_reg, 8'h00};
            txcnt_next = 2'd1;
            state_next = ST_SEND;
          end
          CMD_READ_DMEM: begin
            addr_next  = arg_reg[31:16];
            left_next  = {(arg_reg[15:0] == 16'h0000), arg_reg[15:0]};
            state_next = ST_DREAD;
          end
          CMD_READ_CRC: begin
            if (dmode) begin
              crc_next   = CRC_INIT;
              caddr_next = 17'd0;
              state_next = ST_CRC;
            end else begin
              tx_next = CRC_BLOCKED;
              txcnt_next = 2'd2;
              state_next = ST_SEND;
            end
          end
          CMD_STEP: step_next = exec_ok;
          CMD_STUFF: begin
            cbyte_next = arg_reg[7:0];
            stuff_next = exec_ok;
          end
          CMD_EXEC: begin
            cbyte_next = arg_reg[7:0];
            exv_next   = exec_ok;
            exf_next   = 1'b1;
            state_next = ST_ELEN;
          end
          default: state_next = ST_CMD;
        endcase
      end
      ST_ELEN: begin
        // Decoder length of the opcode now on cpu_byte
        exf_next = 1'b0;
        if (cpu_instr_len > 3'd1) begin
          argcnt_next = cpu_instr_len - 3'd1;
          state_next  = ST_EXEC;
        end else begin
          state_next = ST_CMD;
        end
      end
      ST_EXEC: begin
        if (rx) begin
          cbyte_next  = link.h2d_data;
          exv_next    = exec_ok;
          argcnt_next = argcnt_reg - 3'd1;
          if (argcnt_reg == 3'd1) begin
            state_next = ST_CMD;
          end
        end
      end
      ST_DREAD: begin
        addr_next = addr_reg + 16'd1;
        left_next = left_reg - 17'd1;
        if (dmode) begin
          dmem_rd_next   = 1'b1;
          dmem_addr_next = addr_reg;
          state_next     = ST_DWAIT;
        end else begin
          tx_next    = {DATA_BLOCKED, 8'h00};
          txcnt_next = 2'd1;
          state_next = ST_SEND;
        end
      end
      ST_DWAIT: begin
        if (dmem_rd_d_reg) begin
          tx_next    = {dmem_rdata, 8'h00};
          txcnt_next = 2'd1;
          state_next = ST_SEND;
        end
      end
      ST_CRC: begin
        // Pipelined walk: one byte per cycle, so the wait tracks memory size
        if (caddr_reg < PMEM_END) begin
          pmem_rd_next   = 1'b1;
          pmem_addr_next = caddr_reg[15:0];
          caddr_next     = caddr_reg + 17'd1;
        end
        if (pmem_rd_d_reg) begin
          crc_next = crc_byte(crc_reg, pmem_rdata);
        end
        if (caddr_reg == PMEM_END && !pmem_rd_reg && !pmem_rd_d_reg) begin
          tx_next    = crc_reg;
          txcnt_next = 2'd2;
          state_next = ST_SEND;
        end
      end
      ST_SEND: begin
        if ((!d2h_valid_reg || txdone) && txcnt_reg != 2'd0) begin
          d2h_data_next  = tx_reg[15:8];
          d2h_valid_next = 1'b1;
          tx_next        = {tx_reg[7:0], 8'h00};
          txcnt_next     = txcnt_reg - 2'd1;
        end
        if (txdone && txcnt_reg == 2'd0) begin
          state_next = (cmd_reg == CMD_READ_DMEM && left_reg != 17'd0) ? ST_DREAD : ST_CMD;
        end
      end
      default: state_next = ST_CMD;
    endcase
    // Runtime counter: run outside debug, restart on leaving it, hold at max
    if (dmode && !ctrl_next[CTRL_DEBUG_BIT]) begin
      runtime_next = 16'h0000;
    end else if (!dmode && runtime_reg != RUNTIME_MAX) begin
      runtime_next = runtime_reg + 16'd1;
    end
    h2d_ready_next = (state_next == ST_CMD) || (state_next == ST_ARG)
                     || (state_next == ST_EXEC);
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= ST_CMD;
      cmd_reg       <= 8'h00;
      arg_reg       <= 32'h0000_0000;
      argcnt_reg    <= 3'd0;
      tx_reg        <= 16'h0000;
      txcnt_reg     <= 2'd0;
      ctrl_reg      <= CTRL_RESET;
      runtime_reg   <= 16'h0000;
      addr_reg      <= 16'h0000;
      left_reg      <= 17'd0;
      crc_reg       <= CRC_INIT;
      caddr_reg     <= 17'd0;
      h2d_ready_reg <= 1'b0;
      d2h_data_reg  <= 8'h00;
      d2h_valid_reg <= 1'b0;
      dmem_rd_reg   <= 1'b0;
      dmem_rd_d_reg <= 1'b0;
      dmem_addr_reg <= 16'h0000;
      pmem_rd_reg   <= 1'b0;
      pmem_rd_d_reg <= 1'b0;
      pmem_addr_reg <= 16'h0000;
      bkpt_reg      <= 1'b0;
      step_reg      <= 1'b0;
      stuff_reg     <= 1'b0;
      exv_reg       <= 1'b0;
      exf_reg       <= 1'b0;
      cbyte_reg     <= 8'h00;
      prot_reg      <= PROT_NONE;
    end else begin
      state_reg     <= state_next;
      cmd_reg       <= cmd_next;
      arg_reg       <= arg_next;
      argcnt_reg    <= argcnt_next;
      tx_reg        <= tx_next;
      txcnt_reg     <= txcnt_next;
      ctrl_reg      <= ctrl_next;
      runtime_reg   <= runtime_next;
      addr_reg      <= addr_next;
      left_reg      <= left_next;
      crc_reg       <= crc_next;
      caddr_reg     <= caddr_next;
      h2d_ready_reg <= h2d_ready_next;
      d2h_data_reg  <= d2h_data_next;
      d2h_valid_reg <= d2h_valid_next;
      dmem_rd_reg   <= dmem_rd_next;
      dmem_rd_d_reg <= dmem_rd_reg;
      dmem_addr_reg <= dmem_addr_next;
      pmem_rd_reg   <= pmem_rd_next;
      pmem_rd_d_reg <= pmem_rd_reg;
      pmem_addr_reg <= pmem_addr_next;
      bkpt_reg      <= bkpt_next;
      step_reg      <= step_next;
      stuff_reg     <= stuff_next;
      exv_reg       <= exv_next;
      exf_reg       <= exf_next;
      cbyte_reg     <= cbyte_next;
      prot_reg      <= prot_next;
    end
  end

  // Outputs straight from flip-flops
  assign link.h2d_ready         = h2d_ready_reg;
  assign link.d2h_data          = d2h_data_reg;
  assign link.d2h_valid         = d2h_valid_reg;
  assign protect_level          = prot_reg;
  assign debug_mode_control_bit = ctrl_reg[CTRL_DEBUG_BIT];
  assign dmem_rd                = dmem_rd_reg;
  assign dmem_addr              = dmem_addr_reg;
  assign pmem_rd                = pmem_rd_reg;
  assign pmem_addr              = pmem_addr_reg;
  assign breakpoint_hit         = bkpt_reg;
  assign cpu_step               = step_reg;
  assign cpu_stuff              = stuff_reg;
  assign cpu_exec_valid         = exv_reg;
  assign cpu_exec_first         = exf_reg;
  assign cpu_byte               = cbyte_reg;
endmodule // odcu_device

// ### verilog/odcu_host.sv
`timescale 1ns/1ps
module odcu_host (
  odcu_link_if.host        link,
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [15:0] cmd_size,
  input  wire logic [7:0]  cmd_arg,
  input  wire logic [39:0] cmd_instr,
  input  wire logic [2:0]  cmd_len,
  output logic             cmd_ready,
  output logic             resp_valid,
  output logic [7:0]       resp_data,
  output logic             cmd_done
);
  import odcu_pkg::*;

  odcu_hstate_type state_reg, state_next;
  logic [47:0] buf_reg, buf_next;
  logic [2:0]  ntx_reg, ntx_next;
  logic [16:0] nrx_reg, nrx_next;
  logic        h2d_valid_reg, h2d_valid_next;
  logic [7:0]  h2d_data_reg, h2d_data_next;
  logic        d2h_ready_reg, d2h_ready_next;
  logic        ready_reg, ready_next;
  logic        rv_reg, rv_next;
  logic [7:0]  rd_reg, rd_next;
  logic        done_reg, done_next;
  logic        sent, got;

  // Frame builder and byte sequencer
  always_comb begin
    state_next     = state_reg;
    buf_next       = buf_reg;
    ntx_next       = ntx_reg;
    nrx_next       = nrx_reg;
    h2d_valid_next = h2d_valid_reg;
    h2d_data_next  = h2d_data_reg;
    rv_next        = 1'b0;
    rd_next        = rd_reg;
    done_next      = 1'b0;
    sent = h2d_valid_reg && link.h2d_ready;
    got  = d2h_ready_reg && link.d2h_valid;
    case (state_reg)
      H_IDLE: begin
        if (cmd_valid) begin
          buf_next = {cmd_code, 40'h00_0000_0000};
          ntx_next = 3'd1;
          nrx_next = 17'd0;
          case (cmd_code)
            CMD_READ_REV, CMD_READ_RUNTIME, CMD_READ_CRC: nrx_next = 17'd2;
            CMD_READ_STATUS, CMD_READ_CTRL: nrx_next = 17'd1;
            CMD_WRITE_CTRL, CMD_STUFF: begin
              buf_next[39:32] = cmd_arg;
              ntx_next = 3'd2;
            end
            CMD_READ_DMEM: begin
              buf_next[39:8] = {cmd_addr, cmd_size};
              ntx_next = 3'd5;
              nrx_next = {(cmd_size == 16'h0000), cmd_size};
            end
            CMD_EXEC: begin
              buf_next[39:0] = cmd_instr;
              ntx_next = cmd_len + 3'd1;
            end
            default: nrx_next = 17'd0;
          endcase
          h2d_data_next  = buf_next[47:40];
          h2d_valid_next = 1'b1;
          buf_next       = {buf_next[39:0], 8'h00};
          state_next     = H_TX;
        end
      end
      H_TX: begin
        if (sent) begin
          ntx_next = ntx_reg - 3'd1;
          if (ntx_reg == 3'd1) begin
            h2d_valid_next = 1'b0;
            state_next = (nrx_reg != 17'd0) ? H_RX : H_IDLE;
            done_next  = (nrx_reg == 17'd0);
          end else begin
            h2d_data_next = buf_reg[47:40];
            buf_next      = {buf_reg[39:0], 8'h00};
          end
        end
      end
      H_RX: begin
        if (got) begin
          rv_next  = 1'b1;
          rd_next  = link.d2h_data;
          nrx_next = nrx_reg - 17'd1;
          if (nrx_reg == 17'd1) begin
            state_next = H_IDLE;
            done_next  = 1'b1;
          end
        end
      end
      default: state_next = H_IDLE;
    endcase
    d2h_ready_next = (state_next == H_RX);
    ready_next     = (state_next == H_IDLE);
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= H_IDLE;
      buf_reg       <= 48'h0000_0000_0000;
      ntx_reg       <= 3'd0;
      nrx_reg       <= 17'd0;
      h2d_valid_reg <= 1'b0;
      h2d_data_reg  <= 8'h00;
      d2h_ready_reg <= 1'b0;
      ready_reg     <= 1'b1;
      rv_reg        <= 1'b0;
      rd_reg        <= 8'h00;
      done_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      buf_reg       <= buf_next;
      ntx_reg       <= ntx_next;
      nrx_reg       <= nrx_next;
      h2d_valid_reg <= h2d_valid_next;
      h2d_data_reg  <= h2d_data_next;
      d2h_ready_reg <= d2h_ready_next;
      ready_reg     <= ready_next;
      rv_reg        <= rv_next;
      rd_reg        <= rd_next;
      done_reg      <= done_next;
    end
  end

  assign link.h2d_valid = h2d_valid_reg;
  assign link.h2d_data  = h2d_data_reg;
  assign link.d2h_ready = d2h_ready_reg;
  assign cmd_ready      = ready_reg;
  assign resp_valid     = rv_reg;
  assign resp_data      = rd_reg;
  assign cmd_done       = done_reg;
endmodule // odcu_host

// ### test/odcu_link_properties.sv
`timescale 1ns/1ps
// Handshake and ordering checks on the link between the two ends
module odcu_link_properties (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Offered bytes waiting in each direction, and taken bytes in the reply direction
  sequence s_h2d_wait; h2d_valid && !h2d_ready; endsequence
  sequence s_d2h_wait; d2h_valid && !d2h_ready; endsequence
  sequence s_d2h_take; d2h_valid && d2h_ready; endsequence
  property p_h2d_hold; s_h2d_wait |=> h2d_valid && $stable(h2d_data); endproperty
  a_h2d_hold: assert property (p_h2d_hold) else $error("host byte moved");
  property p_d2h_hold; s_d2h_wait |=> d2h_valid && $stable(d2h_data); endproperty
  a_d2h_hold: assert property (p_d2h_hold) else $error("reply byte moved");
  property p_h2d_take; h2d_valid |-> ##[0:4] h2d_ready; endproperty
  a_h2d_take: assert property (p_h2d_take) else $error("host byte not taken");
  property p_d2h_claim; s_d2h_take |=> !d2h_valid || d2h_ready; endproperty
  a_d2h_claim: assert property (p_d2h_claim) else $error("reply byte unclaimed");
  property p_d2h_next; s_d2h_take |-> ##[1:8] (h2d_ready || d2h_valid); endproperty
  a_d2h_next: assert property (p_d2h_next) else $error("link stalled");
  property p_reply_busy; d2h_valid |-> !h2d_ready; endproperty
  a_reply_busy: assert property (p_reply_busy) else $error("input open in reply");
  property p_host_quiet; d2h_valid |-> !h2d_valid; endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("host sent in reply");
  property p_host_drain; d2h_valid |-> ##[0:2] d2h_ready; endproperty
  a_host_drain: assert property (p_host_drain) else $error("host not draining");
endmodule // odcu_link_properties

// ### test/test_onchip_debug_command_unit.sv
`timescale 1ns/1ps
module test_onchip_debug_command_unit;
  import odcu_pkg::*;
  logic        clk, rst_n, rp_opt, wp_opt, fetch_valid, cmd_valid, debug_bit, bp_hit;
  logic        dmem_rd, pmem_rd, cpu_step, cpu_stuff, cpu_exec_valid, cpu_exec_first;
  logic        cmd_ready, resp_valid, cmd_done;
  logic [7:0]  fetch_opcode, dmem_rdata, pmem_rdata, cmd_code, cmd_arg, resp_data, cpu_byte;
  logic [15:0] cmd_addr, cmd_size, dmem_addr, pmem_addr, r1;
  logic [39:0] cmd_instr;
  logic [2:0]  cmd_len, cpu_instr_len;
  logic [1:0]  protect_level;
  logic [7:0]  q[$];
  int          bad_count, check_count, cyc, n_step, n_stuff, n_exec, t0, n_brk, n_first;

  odcu_link_if odcu_link_if_inst();
  odcu_device #(.PMEM_BYTES(16)) odcu_device_inst (.link(odcu_link_if_inst.device), .clk,
    .rst_n, .flash_read_protect_option(rp_opt), .flash_write_protect_option(wp_opt),
    .protect_level, .debug_mode_control_bit(debug_bit), .dmem_rd, .dmem_addr, .dmem_rdata,
    .pmem_rd, .pmem_addr, .pmem_rdata, .fetch_valid, .fetch_opcode, .breakpoint_hit(bp_hit),
    .cpu_step, .cpu_stuff, .cpu_exec_valid, .cpu_exec_first, .cpu_byte, .cpu_instr_len);
  odcu_host odcu_host_inst (.link(odcu_link_if_inst.host), .clk, .rst_n, .cmd_valid,
    .cmd_code, .cmd_addr, .cmd_size, .cmd_arg, .cmd_instr, .cmd_len, .cmd_ready, .resp_valid,
    .resp_data, .cmd_done);
  odcu_link_properties odcu_link_properties_inst (.clk, .rst_n,
    .h2d_data(odcu_link_if_inst.h2d_data), .h2d_valid(odcu_link_if_inst.h2d_valid),
    .h2d_ready(odcu_link_if_inst.h2d_ready), .d2h_data(odcu_link_if_inst.d2h_data),
    .d2h_valid(odcu_link_if_inst.d2h_valid), .d2h_ready(odcu_link_if_inst.d2h_ready));

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Memories answer a cycle after the address, replies and cpu pulses collected, timeout
  always @(posedge clk) begin
    dmem_rdata <= dmem_addr[7:0] ^ 8'h5A;
    pmem_rdata <= pmem_addr[7:0];
    if (resp_valid === 1'b1) q.push_back(resp_data);
    n_step += int'(cpu_step === 1'b1);
    n_stuff += int'(cpu_stuff === 1'b1);
    n_exec += int'(cpu_exec_valid === 1'b1);
    n_first += int'(cpu_exec_first === 1'b1 && cpu_exec_valid === 1'b1);
    n_brk += int'(bp_hit === 1'b1);
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One command through the host end, waiting for its completion
  task automatic run(input logic [7:0] c, input logic [15:0] a, s, input logic [7:0] g);
    int n;
    @(posedge clk);
    #2;
    q.delete();
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    cmd_size = s;
    cmd_arg = g;
    do @(posedge clk); while (cmd_ready !== 1'b1);
    #2;
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    check(n < 3000, 1);
    // Let the cpu pulses of the command land before anything is compared
    repeat (2) @(posedge clk);
    #2;
  endtask

  task automatic c0(input logic [7:0] c);
    run(c, 16'h0000, 16'h0000, 8'h00);
  endtask

  // CRC of program bytes that equal their address
  function automatic logic [15:0] crc16(input int n);
    logic [15:0] c;
    c = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ i[b]) ? 16'h1021 : 16'h0000);
      end
    end
    return c;
  endfunction

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n, rp_opt, wp_opt, fetch_valid, cmd_valid} = 5'h00;
    {fetch_opcode, cmd_code, cmd_arg, cmd_addr, cmd_size} = 56'h0;
    {dmem_rdata, pmem_rdata} = 16'h0000;
    cmd_instr = 40'hA1_B2C3_0000;
    cmd_len = 3'h3;
    cpu_instr_len = 3'h3;
    {bad_count, check_count, cyc, n_step, n_stuff, n_exec, n_brk, n_first} = '0;
    repeat (10) @(posedge clk);
    #2;
    rst_n = 1'b1;
    c0(CMD_READ_REV);
    check({q[0], q[1]}, DEBUG_REVISION);
    c0(CMD_READ_STATUS);
    check(q[0] & 8'hE0, 8'h00);
    c0(CMD_READ_RUNTIME);
    check({q[0], q[1]}, 16'hFFFF);
    c0(CMD_RESERVED);
    check(q.size(), 0);
    run(CMD_READ_DMEM, 16'h0010, 16'h0002, 8'h00);
    check({q[0], q[1]}, 16'hFFFF);
    check(q.size(), 2);
    c0(CMD_READ_CRC);
    check({q[0], q[1]}, 16'hFFFF);
    c0(CMD_STEP);
    check(n_step, 0);
    $display("test normal mode done");
    for (int i = 0; i < 4; i++) begin
      {wp_opt, rp_opt} = 2'(i);
      repeat (3) @(posedge clk);
      check(protect_level, (i > 1) ? 2 : i);
      #2;
    end
    {wp_opt, rp_opt} = 2'h0;
    $display("test protection levels done");
    run(CMD_WRITE_CTRL, 16'h0000, 16'h0000, 8'h80);
    c0(CMD_READ_CTRL);
    check(q[0], 8'h80);
    run(CMD_READ_DMEM, 16'h0010, 16'h0003, 8'h00);
    check({q[0], q[1], q[2]}, 32'h004A_4B48);
    t0 = cyc;
    c0(CMD_READ_CRC);
    check({q[0], q[1]}, crc16(16));
    check(cyc - t0 > 16, 1);
    c0(CMD_STEP);
    check(n_step, 1);
    run(CMD_STUFF, 16'h0000, 16'h0000, 8'hA5);
    check({n_stuff[7:0], cpu_byte}, 16'h01A5);
    c0(CMD_EXEC);
    check(n_exec, 3);
    check(n_first, 1);
    rp_opt = 1'b1;
    run(CMD_WRITE_CTRL, 16'h0000, 16'h0000, 8'h00);
    c0(CMD_READ_CTRL);
    check(q[0][7], 1'b1);
    c0(CMD_READ_STATUS);
    check(q[0] & 8'hE0, 8'hC0);
    c0(CMD_STEP);
    run(CMD_STUFF, 16'h0000, 16'h0000, 8'h5A);
    check(n_step + n_stuff, 2);
    rp_opt = 1'b0;
    $display("test debug commands done");
    run(CMD_WRITE_CTRL, 16'h0000, 16'h0000, 8'h40);
    repeat (40) @(posedge clk);
    #2;
    fetch_opcode = BREAKPOINT_OPCODE;
    fetch_valid = 1'b1;
    @(posedge clk);
    #2;
    fetch_valid = 1'b0;
    repeat (3) @(posedge clk);
    check(debug_bit, 1'b1);
    check(n_brk, 1);
    c0(CMD_READ_RUNTIME);
    r1 = {q[0], q[1]};
    check(r1 >= 16'h0028 && r1 < 16'h0100, 1);
    c0(CMD_READ_RUNTIME);
    check({q[0], q[1]}, r1);
    $display("test breakpoint and runtime done");
    print_verdict();
  end
endmodule // test_onchip_debug_command_unit
